// >>> common/sysctl_pkg.sv
package sysctl_pkg;

    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam int IRQ_COUNT = 32;

    localparam logic [ADDR_W-1:0] OFF_VECTOR_BASE = 8'h08;
    localparam logic [ADDR_W-1:0] OFF_AIRC = 8'h0c;
    localparam logic [ADDR_W-1:0] OFF_SLEEP = 8'h10;
    localparam logic [ADDR_W-1:0] OFF_POWER_STATUS = 8'h14;

    // offset field spans bits 31..7, this build keeps bits 29..7
    localparam logic [DATA_W-1:0] VTB_FIELD_MASK = 32'hffff_ff80;
    localparam logic [DATA_W-1:0] VTB_IMPL_MASK = 32'h3fff_ff80;
    localparam logic [DATA_W-1:0] VTB_RESET = 32'h0000_0000;

    localparam int KEY_LSB = 16;
    localparam int KEY_MSB = 31;
    localparam logic [15:0] WRITE_KEY = 16'h05fa;
    // arbitrary value, the readback field is undefined
    localparam logic [15:0] KEY_READBACK = 16'h0000;
    localparam int AIRC_ENDIAN_BIT = 15;
    localparam int AIRC_RESET_BIT = 2;
    localparam int AIRC_CLR_BIT = 1;

    localparam int SLP_PEND_BIT = 4;
    localparam int SLP_DEEP_BIT = 2;
    localparam int SLP_EXIT_BIT = 1;
    localparam logic DEEP_SLEEP_IMPL = 1'b1;

    localparam int PWR_SLEEPING_BIT = 0;
    localparam int PWR_DEEP_BIT = 1;
    localparam int PWR_WAIT_EVENT_BIT = 2;
    localparam int PWR_HALTED_BIT = 3;
    localparam int PWR_EVENT_LATCH_BIT = 4;

    typedef enum logic [1:0] {
        pwr_run,
        pwr_wait_irq,
        pwr_wait_event
    } power_state_t;

    function automatic logic addr_hit(
        input logic [ADDR_W-1:0] addr,
        input logic [ADDR_W-1:0] off
    );
        addr_hit = (addr == off);
    endfunction

endpackage

// >>> design/pend_wake_detect.sv
`timescale 1ns/10ps
// one-cycle pulse when any interrupt goes from inactive to pending
module pend_wake_detect (
    input wire logic ref_clk,
    input wire logic reset,
    input wire logic enable,
    input wire logic [sysctl_pkg::IRQ_COUNT-1:0] irq_pending,
    output logic wake_q
);
    logic [sysctl_pkg::IRQ_COUNT-1:0] prev_q;

    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            prev_q <= '0;
        end else begin
            prev_q <= irq_pending;
        end
    end

    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            wake_q <= 1'b0;
        end else begin
            wake_q <= enable && |(irq_pending & ~prev_q);
        end
    end
endmodule // pend_wake_detect

// >>> design/pin_sync.sv
`timescale 1ns/10ps
// three-stage capture, a change counts once stages two and three agree
module pin_sync (
    input wire logic ref_clk,
    input wire logic reset,
    input wire logic pin_in,
    output logic level_q
);
    logic s1_q;
    logic s2_q;
    logic s3_q;

    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            s1_q <= 1'b0;
            s2_q <= 1'b0;
            s3_q <= 1'b0;
        end else begin
            s1_q <= pin_in;
            s2_q <= s1_q;
            s3_q <= s2_q;
        end
    end

    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            level_q <= 1'b0;
        end else if (s2_q == s3_q) begin
            level_q <= s3_q;
        end
    end
endmodule // pin_sync

// >>> design/sysctl_regs.sv
`timescale 1ns/10ps
// vector base, interrupt/reset control and sleep control registers
module sysctl_regs (
    input wire logic ref_clk,
    input wire logic reset,
    input wire logic [sysctl_pkg::ADDR_W-1:0] addr,
    input wire logic [sysctl_pkg::DATA_W-1:0] wr_data,
    input wire logic wr_en,
    input wire logic rd_en,
    output logic [sysctl_pkg::DATA_W-1:0] rd_data,
    input wire logic [sysctl_pkg::DATA_W-1:0] vector_base_cfg,
    input wire logic vector_base_cfg_valid,
    input wire logic big_endian_pin,
    input wire logic debug_halted,
    input wire logic [sysctl_pkg::IRQ_COUNT-1:0] irq_pending,
    input wire logic external_event,
    input wire logic wait_for_interrupt_hint,
    input wire logic wait_for_event_hint,
    input wire logic handler_return_base,
    output logic [sysctl_pkg::DATA_W-1:0] vector_table_base_out,
    output logic system_reset_request,
    output logic clear_active_state,
    output logic sleeping,
    output logic deep_sleep,
    output logic wakeup_event
);

    // stored register state
    logic [sysctl_pkg::DATA_W-1:0] vtb_q;
    logic init_done_q;
    logic reset_req_q;
    logic clear_active_q;
    logic pend_wake_en_q;
    logic deep_select_q;
    logic sleep_exit_q;
    logic event_latch_q;
    logic wake_out_q;
    logic sleeping_q;
    logic deep_q;
    logic [sysctl_pkg::DATA_W-1:0] rd_data_q;
    sysctl_pkg::power_state_t state_q;
    sysctl_pkg::power_state_t state_d;

    // decoded bus strobes
    logic wr_vtb;
    logic wr_airc;
    logic wr_sleep;
    logic key_ok;
    logic big_endian;
    logic pend_wake;
    logic any_wake;
    logic any_irq;
    logic consume_event;
    logic keyed_airc;
    logic req_set;
    logic clr_set;
    logic keep_event;

    // shared by both sleep outputs so they can never disagree
    function automatic logic is_asleep(input sysctl_pkg::power_state_t s);
        is_asleep = (s != sysctl_pkg::pwr_run);
    endfunction

    assign wr_vtb = wr_en
        && sysctl_pkg::addr_hit(addr, sysctl_pkg::OFF_VECTOR_BASE);
    assign wr_airc = wr_en
        && sysctl_pkg::addr_hit(addr, sysctl_pkg::OFF_AIRC);
    assign wr_sleep = wr_en
        && sysctl_pkg::addr_hit(addr, sysctl_pkg::OFF_SLEEP);

    assign key_ok = (wr_data[sysctl_pkg::KEY_MSB:sysctl_pkg::KEY_LSB]
        == sysctl_pkg::WRITE_KEY);

    // a control write without the key is dropped as a whole
    assign keyed_airc = wr_airc && key_ok;
    assign req_set = keyed_airc && wr_data[sysctl_pkg::AIRC_RESET_BIT];
    // outside debug halt the effect is undefined, so it is ignored
    // dropped unless halted
    assign clr_set = keyed_airc && debug_halted
        && wr_data[sysctl_pkg::AIRC_CLR_BIT];

    // any pending line, enabled as a wake event or not, ends a wait
    assign any_irq = |irq_pending;
    // an external event wakes a wait-for-event sleep like a pending rise
    assign any_wake = pend_wake || external_event;

    // byte order strap comes from a pin, so it is synchronised
    pin_sync endian_sync (
        .ref_clk(ref_clk),
        .reset(reset),
        .pin_in(big_endian_pin),
        .level_q(big_endian)
    );

    // pending rise detector, gated by the wake enable bit
    pend_wake_detect wake_detect (
        .ref_clk(ref_clk),
        .reset(reset),
        .enable(pend_wake_en_q),
        .irq_pending(irq_pending),
        .wake_q(pend_wake)
    );

    // vector table base
    // the config inputs are sampled on the first edge after release,
    // never inside the async reset branch
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            init_done_q <= 1'b0;
        end else begin
            init_done_q <= 1'b1;
        end
    end

    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            vtb_q <= sysctl_pkg::VTB_RESET;
        end else if (wr_vtb) begin
            // a write in the load cycle wins over the config value
            // unimplemented bits dropped
            vtb_q <= wr_data & sysctl_pkg::VTB_IMPL_MASK;
        end else if (!init_done_q) begin
            if (vector_base_cfg_valid) begin
                vtb_q <= vector_base_cfg & sysctl_pkg::VTB_IMPL_MASK;
            end else begin
                vtb_q <= sysctl_pkg::VTB_RESET;
            end
        end
    end

    // bits below the field are wired to zero for the table fetch
    // low address bits zero
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            vector_table_base_out <= sysctl_pkg::VTB_RESET;
        end else begin
            vector_table_base_out <= vtb_q & sysctl_pkg::VTB_FIELD_MASK;
        end
    end

    // interrupt and reset control
    // local reset clears request
    // the request holds until the reset controller pulls reset
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            reset_req_q <= 1'b0;
        end else if (req_set) begin
            reset_req_q <= 1'b1;
        end
    end

    // second stage so the request leaves straight from a flop
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            system_reset_request <= 1'b0;
        end else begin
            system_reset_request <= reset_req_q;
        end
    end

    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            clear_active_q <= 1'b0;
        end else begin
            clear_active_q <= clr_set;
        end
    end

    // one pulse per keyed clear write while halted; back to back writes give two
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            clear_active_state <= 1'b0;
        end else begin
            clear_active_state <= clear_active_q;
        end
    end

    // sleep control
    // plain write, the sleep register carries no key
    // sleep register always present
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            pend_wake_en_q <= 1'b0;
            deep_select_q <= 1'b0;
            sleep_exit_q <= 1'b0;
        end else if (wr_sleep) begin
            pend_wake_en_q <= wr_data[sysctl_pkg::SLP_PEND_BIT];
            deep_select_q <= wr_data[sysctl_pkg::SLP_DEEP_BIT]
                && sysctl_pkg::DEEP_SLEEP_IMPL;
            sleep_exit_q <= wr_data[sysctl_pkg::SLP_EXIT_BIT];
        end
    end

    // power state machine
    always_comb begin
        state_d = state_q;
        consume_event = 1'b0;
        case (state_q)
            sysctl_pkg::pwr_run: begin
                // a halted core runs no code, so no hint can count
                if (debug_halted) begin
                    state_d = sysctl_pkg::pwr_run;
                end else if (wait_for_interrupt_hint) begin
                    state_d = sysctl_pkg::pwr_wait_irq;
                end else if (wait_for_event_hint) begin
                    // a latched event lets the hint fall through
                    if (event_latch_q || any_wake) begin
                        consume_event = 1'b1;
                    end else begin
                        state_d = sysctl_pkg::pwr_wait_event;
                    end
                end else if (handler_return_base && sleep_exit_q) begin
                    state_d = sysctl_pkg::pwr_wait_irq;
                end
            end
            sysctl_pkg::pwr_wait_irq: begin
                // a wake event alone does not end this wait
                if (any_irq || debug_halted) begin
                    state_d = sysctl_pkg::pwr_run;
                end
            end
            sysctl_pkg::pwr_wait_event: begin
                if (any_wake || any_irq || debug_halted) begin
                    state_d = sysctl_pkg::pwr_run;
                    // the wake that ends the wait is used up by it
                    consume_event = 1'b1;
                end
            end
            default: begin
                state_d = sysctl_pkg::pwr_run;
            end
        endcase
    end

    // hints only count in the run state; the sleep states ignore them
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            state_q <= sysctl_pkg::pwr_run;
        end else begin
            state_q <= state_d;
        end
    end

    // a fresh event outlives a hint that only used up the old latch;
    // an event that the hint itself used up is not kept
    assign keep_event = any_wake && state_q == sysctl_pkg::pwr_run
        && !(consume_event && !event_latch_q);

    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            event_latch_q <= 1'b0;
        end else if (keep_event) begin
            // set wins over a clear in the same cycle
            event_latch_q <= 1'b1;
        end else if (consume_event) begin
            event_latch_q <= 1'b0;
        end
    end

    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            sleeping_q <= 1'b0;
            deep_q <= 1'b0;
        end else begin
            sleeping_q <= is_asleep(state_d);
            deep_q <= is_asleep(state_d) && deep_select_q;
        end
    end

    // the wake pulse takes the same two stages as the sleep outputs
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            wake_out_q <= 1'b0;
        end else begin
            wake_out_q <= any_wake;
        end
    end

    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            sleeping <= 1'b0;
            deep_sleep <= 1'b0;
            wakeup_event <= 1'b0;
        end else begin
            sleeping <= sleeping_q;
            deep_sleep <= deep_q;
            wakeup_event <= wake_out_q;
        end
    end

    // register read
    // one aligned word each
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            rd_data_q <= '0;
        end else if (rd_en) begin
            // unmapped words and reserved bits fall through as zero
            rd_data_q <= '0;
            if (sysctl_pkg::addr_hit(addr,
                    sysctl_pkg::OFF_VECTOR_BASE)) begin
                rd_data_q <= vtb_q;
            end else if (sysctl_pkg::addr_hit(addr,
                    sysctl_pkg::OFF_AIRC)) begin
                rd_data_q[sysctl_pkg::KEY_MSB:sysctl_pkg::KEY_LSB]
                    <= sysctl_pkg::KEY_READBACK;
                rd_data_q[sysctl_pkg::AIRC_ENDIAN_BIT] <= big_endian;
            end else if (sysctl_pkg::addr_hit(addr,
                    sysctl_pkg::OFF_SLEEP)) begin
                rd_data_q[sysctl_pkg::SLP_PEND_BIT] <= pend_wake_en_q;
                rd_data_q[sysctl_pkg::SLP_DEEP_BIT] <= deep_select_q;
                rd_data_q[sysctl_pkg::SLP_EXIT_BIT] <= sleep_exit_q;
            end else if (sysctl_pkg::addr_hit(addr,
                    sysctl_pkg::OFF_POWER_STATUS)) begin
                rd_data_q[sysctl_pkg::PWR_SLEEPING_BIT] <= sleeping_q;
                rd_data_q[sysctl_pkg::PWR_DEEP_BIT] <= deep_q;
                rd_data_q[sysctl_pkg::PWR_WAIT_EVENT_BIT] <=
                    (state_q == sysctl_pkg::pwr_wait_event);
                rd_data_q[sysctl_pkg::PWR_HALTED_BIT] <= debug_halted;
                rd_data_q[sysctl_pkg::PWR_EVENT_LATCH_BIT] <=
                    event_latch_q;
            end
        end else begin
            // data stand only in the cycle after the strobe
            rd_data_q <= '0;
        end
    end

    // read data leave straight from the read flop
    assign rd_data = rd_data_q;

endmodule // sysctl_regs

// >>> dv/sys_reset_ctrl.sv
`timescale 1ns/10ps
// far-side reset controller; the delay keeps it from looking instant
module sys_reset_ctrl #(
    parameter int DELAY = 4
) (
    input wire logic ref_clk,
    input wire logic system_reset_request,
    output logic sys_reset
);
    int cnt_q = 0;
    // request answered by a local reset
    always @(posedge ref_clk) begin
        if (system_reset_request !== 1'b1) begin
            cnt_q <= 0;
            sys_reset <= 1'b0;
        end else if (cnt_q == DELAY) begin
            sys_reset <= 1'b1;
        end else begin
            cnt_q <= cnt_q + 1;
        end
    end
endmodule // sys_reset_ctrl

// >>> dv/sysctl_assertions.sv
`timescale 1ns/10ps
module sysctl_checker (
    input wire logic ref_clk,
    input wire logic reset,
    input wire logic [sysctl_pkg::ADDR_W-1:0] addr,
    input wire logic [sysctl_pkg::DATA_W-1:0] wr_data,
    input wire logic wr_en,
    input wire logic rd_en,
    input wire logic [sysctl_pkg::DATA_W-1:0] rd_data,
    input wire logic debug_halted,
    input wire logic wait_for_interrupt_hint,
    input wire logic wait_for_event_hint,
    input wire logic handler_return_base,
    input wire logic [sysctl_pkg::DATA_W-1:0] vector_table_base_out,
    input wire logic system_reset_request,
    input wire logic clear_active_state,
    input wire logic sleeping,
    input wire logic deep_sleep
);
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (reset);
    // only keyed control writes may act
    wire logic key_wr = wr_en && addr == sysctl_pkg::OFF_AIRC
        && wr_data[31:16] == sysctl_pkg::WRITE_KEY;
    wire logic req_wr = key_wr && wr_data[2];
    wire logic clr_wr = key_wr && wr_data[1] && debug_halted;
    wire logic hint = wait_for_interrupt_hint || wait_for_event_hint
        || handler_return_base;
    a_rd_idle_zero: assert property (
        !$past(rd_en) |-> rd_data == 32'h0) else $error("rd_data not idle");
    a_vtb_unimpl: assert property (
        (vector_table_base_out & ~sysctl_pkg::VTB_IMPL_MASK) == 32'h0)
        else $error("unimplemented vector bits set");
    a_ctl_rsvd_zero: assert property (
        rd_en && addr == sysctl_pkg::OFF_AIRC |=> rd_data[31:16] == 16'h0
        && rd_data[14:0] == 15'h0) else $error("control read bits");
    a_req_fire: assert property (
        req_wr |-> ##2 system_reset_request) else $error("no reset request");
    a_req_cause: assert property (
        $rose(system_reset_request) |-> $past(req_wr, 2))
        else $error("reset request without keyed write");
    a_req_hold: assert property (
        system_reset_request |=> system_reset_request)
        else $error("reset request dropped");
    a_clr_fire: assert property (
        clr_wr |-> ##2 clear_active_state) else $error("no clear pulse");
    a_clr_cause: assert property (
        clear_active_state |-> $past(clr_wr, 2))
        else $error("clear pulse without cause");
    a_deep_asleep: assert property (
        deep_sleep |-> sleeping) else $error("deep sleep while awake");
    a_sleep_cause: assert property (
        $rose(sleeping) |-> $past(hint, 2)) else $error("sleep without hint");
    c_req: cover property (req_wr ##2 system_reset_request);
    c_clr: cover property (clr_wr ##2 clear_active_state);
    c_deep: cover property ($rose(deep_sleep));
endmodule // sysctl_checker

bind sysctl_regs sysctl_checker sysctl_checker_inst (
    .ref_clk, .reset, .addr, .wr_data, .wr_en, .rd_en, .rd_data,
    .debug_halted, .wait_for_interrupt_hint, .wait_for_event_hint,
    .handler_return_base, .vector_table_base_out,
    .system_reset_request, .clear_active_state, .sleeping, .deep_sleep
);

// >>> dv/tb.sv
`timescale 1ns/10ps
module tb;
    localparam logic [7:0] va = sysctl_pkg::OFF_VECTOR_BASE;
    localparam logic [7:0] ac = sysctl_pkg::OFF_AIRC;
    localparam logic [7:0] sl = sysctl_pkg::OFF_SLEEP;
    localparam logic [31:0] im = sysctl_pkg::VTB_IMPL_MASK;
    logic ref_clk = 1'b0;
    logic por = 1'b1;
    logic sys_reset, reset, rd_v, system_reset_request, clear_active_state;
    logic sleeping, deep_sleep, wakeup_event;
    logic [7:0] addr = 8'h00;
    logic [31:0] wr_data = 32'h0;
    logic [31:0] irq_pending = 32'h0;
    logic [31:0] vector_base_cfg, rd_data, vector_table_base_out;
    logic wr_en = 1'b0;
    logic rd_en = 1'b0;
    logic vector_base_cfg_valid = 1'b1;
    logic big_endian_pin = 1'b0;
    logic debug_halted = 1'b0;
    logic external_event = 1'b0;
    logic [2:0] hint = 3'h0;
    logic [31:0] rnd = 32'he80d;
    logic [31:0] exp_q[$];
    int err_count = 0;
    int checked = 0;
    int clr_n = 0;
    int wk_n = 0;
    int cyc = 0;

    always #5 ref_clk = ~ref_clk;
    assign reset = por | sys_reset;

    sysctl_regs sysctl_regs_inst (
        .ref_clk, .reset, .addr, .wr_data, .wr_en, .rd_en, .rd_data,
        .vector_base_cfg, .vector_base_cfg_valid, .big_endian_pin,
        .debug_halted, .irq_pending, .external_event,
        .wait_for_interrupt_hint(hint[0]), .wait_for_event_hint(hint[1]),
        .handler_return_base(hint[2]), .vector_table_base_out,
        .system_reset_request, .clear_active_state, .sleeping, .deep_sleep,
        .wakeup_event
    );
    sys_reset_ctrl sys_reset_ctrl_inst (
        .ref_clk, .system_reset_request, .sys_reset
    );

    function automatic logic [31:0] xs(input logic [31:0] v);
        logic [31:0] x;
        x = v ^ (v << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            err_count++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic results();
        $display("checked=%0d err_count=%0d", checked, err_count);
        if (err_count == 0 && checked > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge ref_clk);
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        addr <= a;
        wr_data <= d;
        wr_en <= 1'b1;
        @(posedge ref_clk);
        wr_en <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        @(posedge ref_clk);
        addr <= a;
        rd_en <= 1'b1;
        exp_q.push_back(e);
        @(posedge ref_clk);
        rd_en <= 1'b0;
    endtask

    task automatic pulse(input int k);
        @(posedge ref_clk);
        hint <= 3'h1 << k;
        @(posedge ref_clk);
        hint <= 3'h0;
    endtask

    // read data is settled by the falling edge of its one valid cycle
    always @(posedge ref_clk) rd_v <= rd_en;
    always @(negedge ref_clk) begin
        if (rd_v) chk(rd_data, exp_q.pop_front());
        clr_n += int'(clear_active_state);
        wk_n += int'(wakeup_event);
        cyc++;
        if (cyc == 3000) begin
            err_count++;
            results();
        end
    end

    initial begin
        int k;
        rnd = xs(rnd);
        vector_base_cfg = rnd;
        tick(2);
        por <= 1'b0;
        tick(2);
        rd(va, rnd & im);
        wr(va, 32'hffff_ffff);
        rd(va, im);
        rnd = xs(rnd);
        wr(va, rnd);
        rd(va, rnd & im);
        tick(1);
        chk(vector_table_base_out, rnd & im);
        big_endian_pin <= 1'b1;
        tick(6);
        rd(ac, 32'h0000_8000);
        wr(8'h40, 32'hffff_ffff);
        rd(8'h40, 32'h0);
        wr(sl, 32'hffff_ffff);
        rd(sl, 32'h16);
        $display("registers done");
        debug_halted <= 1'b1;
        k = clr_n;
        wr(ac, 32'h0000_0002);
        wr(ac, 32'h05fa_0000);
        tick(3);
        chk(32'(clr_n - k), 32'h0);
        wr(ac, 32'h05fa_0002);
        tick(3);
        debug_halted <= 1'b0;
        chk(32'(clr_n - k), 32'h1);
        wr(ac, 32'h05fa_0002);
        tick(3);
        chk(32'(clr_n - k), 32'h1);
        $display("clear active done");
        wr(sl, 32'h0000_0006);
        for (k = 0; k < 3; k++) begin
            pulse(k);
            tick(3);
            #1 chk({30'h0, deep_sleep, sleeping}, 32'h3);
            rd(8'h14, {29'h0, k == 1, 2'b11});
            rnd = xs(rnd);
            irq_pending <= rnd | 32'h1;
            tick(3);
            #1 chk({31'h0, sleeping}, 32'h0);
            @(posedge ref_clk);
            irq_pending <= 32'h0;
        end
        wr(sl, 32'h0);
        pulse(2);
        tick(3);
        #1 chk({31'h0, sleeping}, 32'h0);
        $display("sleep done");
        wr(sl, 32'h10);
        k = wk_n;
        irq_pending <= 32'h8000_0000;
        tick(5);
        irq_pending <= 32'h0;
        chk(32'(wk_n - k), 32'h1);
        wr(sl, 32'h0);
        k = wk_n;
        irq_pending <= 32'h1;
        tick(5);
        irq_pending <= 32'h0;
        vector_base_cfg_valid <= 1'b0;
        chk(32'(wk_n - k), 32'h0);
        pulse(1);
        tick(3);
        #1 chk({31'h0, sleeping}, 32'h0);
        pulse(1);
        tick(3);
        #1 chk({31'h0, sleeping}, 32'h1);
        k = wk_n;
        @(posedge ref_clk);
        external_event <= 1'b1;
        @(posedge ref_clk);
        external_event <= 1'b0;
        tick(3);
        #1 chk({31'h0, sleeping}, 32'h0);
        chk(32'(wk_n - k), 32'h1);
        $display("wakeup done");
        wr(ac, 32'h0000_0004);
        tick(3);
        #1 chk({31'h0, system_reset_request}, 32'h0);
        wr(ac, 32'h05fa_0004);
        tick(2);
        #1 chk({31'h0, system_reset_request}, 32'h1);
        k = 0;
        while (system_reset_request === 1'b1 && k < 20) begin
            @(posedge ref_clk);
            k++;
        end
        #1 chk({31'h0, system_reset_request}, 32'h0);
        tick(3);
        rd(va, 32'h0);
        rd(sl, 32'h0);
        tick(2);
        $display("reset request done");
        results();
    end
endmodule // tb
